// ---- dac_word_defs.svh ----
// constants of the dual dac serial word decoder
// assumes inclusion by bare name from the package and the design files
//
// Functional notes
// - a command is one 16-bit word: control byte then data byte
// - bit 15 picks reference: zero internal half-supply, one external
// - bits 7..0 are the code, bit 7 most significant
// - update bit 0, load code 00: both output registers take data byte
// - update bit 0, load code 01: data byte into selected input register
// - update bit 0, load code 10: selected input register copied to output
// - update bit 0, load code 11: data byte straight into selected output
// - update bit 1: load selected input register, then update both outputs
// - bit 12 powers down channel b, bit 11 channel a, independently
// - at reset both input registers clear and stay so until a write
// - until the first write the outputs follow the input registers
// - power-down never changes input or output register contents
// - leaving power-down: valid after 13 us if all down, else 1.6 us
// - host changes data on falling clock edges, device samples on rising
// - command executes when frame select rises after sixteen bits
`ifndef DAC_WORD_DEFS_SVH
`define DAC_WORD_DEFS_SVH

// ----------------------------------------------------------------
// command word layout
// ----------------------------------------------------------------
`define WORD_BITS        16
`define BIT_REF_SEL      15
`define BIT_SIMUL_UPDATE 13
`define BIT_PD_CHAN_B    12
`define BIT_PD_CHAN_A    11
`define BIT_CHAN_SEL     10
`define BIT_LOAD_HI      9
`define BIT_LOAD_LO      8
`define DATA_MSB         7
`define CODE_RESET       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS    5000
`define WAKE_FULL_PS     13000000
`define WAKE_PART_PS     1600
`define WAKE_FULL_CYC    ((`WAKE_FULL_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_PART_CYC    (((`WAKE_PART_PS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- dac_word_pkg.sv ----
// types of the dual dac serial word decoder
// assumes the defs header sits in the same folder
`include "dac_word_defs.svh"
package dac_word_pkg;
	typedef enum logic [1:0] {
		LOAD_BOTH_OUT,
		LOAD_INPUT,
		COPY_TO_OUT,
		LOAD_OUT
	} load_func_t;
	typedef enum logic [1:0] {
		WAKE_IDLE,
		WAKE_PENDING
	} wake_state_t;
endpackage

// ---- wake_timer.sv ----
// power-up settle timer of one output channel
// assumes a synchronous reset and a shared clock enable
`include "dac_word_defs.svh"
module wake_timer #(
	parameter int unsigned FULL_CYC = `WAKE_FULL_CYC,
	parameter int unsigned PART_CYC = `WAKE_PART_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clk_en,
	input  wire logic powerdown,
	input  wire logic full_down,
	output logic      valid
);
	localparam int unsigned CW = $clog2(FULL_CYC + 1);

	dac_word_pkg::wake_state_t state_reg;
	logic [CW-1:0]             count_reg;
	logic                      pd_d_reg;
	logic                      full_reg;

	// ----------------------------------------------------------------
	// exit timing
	// ----------------------------------------------------------------
	wire logic           leaving   = pd_d_reg && !powerdown;
	wire logic [CW-1:0]  load_full = CW'(FULL_CYC - 1);
	wire logic [CW-1:0]  load_part = CW'(PART_CYC - 1);

	// track the down state and count the settle time after release
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= dac_word_pkg::WAKE_IDLE;
			count_reg <= '0;
			pd_d_reg  <= 1'b0;
			full_reg  <= 1'b0;
		end else if (clk_en) begin
			pd_d_reg <= powerdown;
			if (powerdown) begin
				full_reg  <= full_down;
				state_reg <= dac_word_pkg::WAKE_IDLE;
			end else begin
				unique case (state_reg)
					dac_word_pkg::WAKE_IDLE: begin
						if (leaving) begin
							count_reg <= full_reg ? load_full : load_part;
							state_reg <= dac_word_pkg::WAKE_PENDING;
						end
					end
					dac_word_pkg::WAKE_PENDING: begin
						if (count_reg == '0)
							state_reg <= dac_word_pkg::WAKE_IDLE;
						else
							count_reg <= count_reg - 1'b1;
					end
					default: state_reg <= dac_word_pkg::WAKE_IDLE;
				endcase
			end
		end
	end

	// valid once up and settled
	assign valid = !powerdown && !leaving && (state_reg == dac_word_pkg::WAKE_IDLE);
endmodule

// ---- dac_word_decoder.sv ----
// serial command decoder of a dual 8-bit voltage dac
// assumes serial clock, data and frame arrive from pins, asynchronous to clk
`include "dac_word_defs.svh"
module dac_word_decoder #(
	parameter int unsigned WAKE_FULL_CYC = `WAKE_FULL_CYC,
	parameter int unsigned WAKE_PART_CYC = `WAKE_PART_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       serial_clk,
	input  wire logic       serial_data,
	input  wire logic       frame_n,
	output logic [7:0]      code_a,
	output logic [7:0]      code_b,
	output logic            reference_select,
	output logic            powerdown_chan_a,
	output logic            powerdown_chan_b,
	output logic            bias_powerdown,
	output logic            valid_a,
	output logic            valid_b
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdat_sync_reg;
	logic [1:0] frame_sync_reg;
	logic       sclk_d_reg;
	logic       frame_d_reg;

	// two flops per pin, then one stage for edge finding
	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_sync_reg  <= 2'h0;
			sdat_sync_reg  <= 2'h0;
			frame_sync_reg <= 2'h3;
			sclk_d_reg     <= 1'b0;
			frame_d_reg    <= 1'b1;
		end else if (clk_en) begin
			sclk_sync_reg  <= {sclk_sync_reg[0], serial_clk};
			sdat_sync_reg  <= {sdat_sync_reg[0], serial_data};
			frame_sync_reg <= {frame_sync_reg[0], frame_n};
			sclk_d_reg     <= sclk_sync_reg[1];
			frame_d_reg    <= frame_sync_reg[1];
		end
	end

	wire logic sclk_s     = sclk_sync_reg[1];
	wire logic sdat_s     = sdat_sync_reg[1];
	wire logic frame_s    = frame_sync_reg[1];
	wire logic sclk_rise  = sclk_s && !sclk_d_reg;
	wire logic frame_rise = frame_s && !frame_d_reg;
	wire logic frame_fall = !frame_s && frame_d_reg;

	// ----------------------------------------------------------------
	// shift register
	// ----------------------------------------------------------------
	logic [`WORD_BITS-1:0] shift_reg;
	logic [4:0]            count_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_reg <= '0;
			count_reg <= 5'h00;
		end else if (clk_en) begin
			if (frame_fall)
				count_reg <= 5'h00;
			else if (!frame_s && sclk_rise) begin
				shift_reg <= {shift_reg[`WORD_BITS-2:0], sdat_s};
				if (count_reg != 5'h1F)
					count_reg <= count_reg + 5'h01;
			end
		end
	end

	// execute on frame rise after sixteen bits
	wire logic execute = frame_rise && (count_reg == 5'(`WORD_BITS));

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	// bit 14 never read
	wire logic       f_ref     = shift_reg[`BIT_REF_SEL];
	wire logic       f_simul   = shift_reg[`BIT_SIMUL_UPDATE];
	wire logic       f_pd_b    = shift_reg[`BIT_PD_CHAN_B];
	wire logic       f_pd_a    = shift_reg[`BIT_PD_CHAN_A];
	wire logic       f_chan_b  = shift_reg[`BIT_CHAN_SEL];
	// data byte, msb at bit 7
	wire logic [7:0] f_data    = shift_reg[`DATA_MSB:0];
	wire dac_word_pkg::load_func_t f_load =
		dac_word_pkg::load_func_t'({shift_reg[`BIT_LOAD_HI], shift_reg[`BIT_LOAD_LO]});

	// per channel strobes
	wire logic sel_a = !f_chan_b;
	wire logic sel_b = f_chan_b;
	wire logic go_n  = execute && !f_simul;
	wire logic go_s  = execute && f_simul;

	wire logic in_ld_a = (go_n && f_load == dac_word_pkg::LOAD_INPUT && sel_a) || (go_s && sel_a);
	wire logic in_ld_b = (go_n && f_load == dac_word_pkg::LOAD_INPUT && sel_b) || (go_s && sel_b);

	// ----------------------------------------------------------------
	// input and output registers
	// ----------------------------------------------------------------
	logic [7:0] in_a_reg;
	logic [7:0] in_b_reg;
	logic [7:0] out_a_reg;
	logic [7:0] out_b_reg;
	logic [7:0] out_a_next;
	logic [7:0] out_b_next;
	logic       transparent_reg;

	wire logic [7:0] in_a_next = in_ld_a ? f_data : in_a_reg;
	wire logic [7:0] in_b_next = in_ld_b ? f_data : in_b_reg;

	// output register next values per load function
	always_comb begin
		out_a_next = out_a_reg;
		out_b_next = out_b_reg;
		if (go_s) begin
			out_a_next = in_a_next;
			out_b_next = in_b_next;
		end else if (go_n) begin
			unique case (f_load)
				dac_word_pkg::LOAD_BOTH_OUT: begin
					out_a_next = f_data;
					out_b_next = f_data;
				end
				dac_word_pkg::LOAD_INPUT: begin
				end
				dac_word_pkg::COPY_TO_OUT: begin
					if (sel_a)
						out_a_next = in_a_reg;
					else
						out_b_next = in_b_reg;
				end
				dac_word_pkg::LOAD_OUT: begin
					if (sel_a)
						out_a_next = f_data;
					else
						out_b_next = f_data;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			in_a_reg        <= `CODE_RESET;
			in_b_reg        <= `CODE_RESET;
			out_a_reg       <= `CODE_RESET;
			out_b_reg       <= `CODE_RESET;
			transparent_reg <= 1'b1;
		end else if (clk_en) begin
			in_a_reg  <= in_a_next;
			in_b_reg  <= in_b_next;
			out_a_reg <= out_a_next;
			out_b_reg <= out_b_next;
			if (execute)
				transparent_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control latches
	// ----------------------------------------------------------------
	logic ref_reg;
	logic pd_a_reg;
	logic pd_b_reg;

	// reference and power-down latched per word
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_reg  <= 1'b0;
			pd_a_reg <= 1'b0;
			pd_b_reg <= 1'b0;
		end else if (clk_en && execute) begin
			ref_reg  <= f_ref;
			pd_a_reg <= f_pd_a;
			pd_b_reg <= f_pd_b;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			code_a <= `CODE_RESET;
			code_b <= `CODE_RESET;
		end else if (clk_en) begin
			code_a <= transparent_reg ? in_a_reg : out_a_reg;
			code_b <= transparent_reg ? in_b_reg : out_b_reg;
		end
	end

	// both down also stops the bias
	assign reference_select = ref_reg;
	assign powerdown_chan_a = pd_a_reg;
	assign powerdown_chan_b = pd_b_reg;
	assign bias_powerdown   = pd_a_reg && pd_b_reg;

	// ----------------------------------------------------------------
	// settle timers
	// ----------------------------------------------------------------
	// channel a on bit 0, channel b on bit 1
	wire logic [1:0] pd_vec = {pd_b_reg, pd_a_reg};
	wire logic [1:0] valid_vec;

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_wake
			wake_timer #(
				.FULL_CYC (WAKE_FULL_CYC),
				.PART_CYC (WAKE_PART_CYC)
			) u_wake (
				.clk       (clk),
				.reset     (reset),
				.clk_en    (clk_en),
				.powerdown (pd_vec[ch]),
				.full_down (bias_powerdown),
				.valid     (valid_vec[ch])
			);
		end
	endgenerate

	// settle flags per channel
	assign valid_a = valid_vec[0];
	assign valid_b = valid_vec[1];
endmodule

// ---- dac_word_host.sv ----
// serial host model driving the decoder pins
// assumes one caller at a time
module dac_word_host (
	output logic serial_clk,
	output logic serial_data,
	output logic frame_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		frame_n = 1'b1;
	end
	task automatic send(input logic [15:0] w, input int n);
		frame_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			serial_data = w[15 - (k % 16)];
			#24 serial_clk = 1'b1;
			#24 serial_clk = 1'b0;
		end
		#24 frame_n = 1'b1;
		serial_data = ~serial_data; // data line inverted after the frame
	endtask
endmodule

// ---- dac_word_decoder_assertions.sv ----
// assertions on the decoder ports
// assumes wake counts of 20 and 5 cycles
module dac_word_decoder_assertions #(
	parameter int unsigned WAKE_FULL_CYC = 20,
	parameter int unsigned WAKE_PART_CYC = 5
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       frame_n,
	input wire logic [7:0] code_a,
	input wire logic [7:0] code_b,
	input wire logic       reference_select,
	input wire logic       powerdown_chan_a,
	input wire logic       powerdown_chan_b,
	input wire logic       bias_powerdown,
	input wire logic       valid_a,
	input wire logic       valid_b
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// short wake: six cycles low, then settled
	sequence s_part_wake;
		!valid_a[*6] ##1 valid_a;
	endsequence
	// full wake: twenty-one cycles low, then settled
	sequence s_full_wake;
		!valid_a[*7] ##1 !valid_a[*7] ##1 !valid_a[*7] ##1 valid_a;
	endsequence
	property p_down_a;
		powerdown_chan_a |-> !valid_a;
	endproperty
	a_down_a: assert property (p_down_a) else $error("valid_a while down");
	property p_down_b;
		powerdown_chan_b |-> !valid_b;
	endproperty
	a_down_b: assert property (p_down_b) else $error("valid_b while down");
	property p_bias;
		bias_powerdown == (powerdown_chan_a && powerdown_chan_b);
	endproperty
	a_bias: assert property (p_bias) else $error("bias mismatch");
	property p_wake_part;
		$fell(powerdown_chan_a) && !$past(powerdown_chan_b) |-> s_part_wake;
	endproperty
	a_wake_part: assert property (p_wake_part) else $error("short wake");
	property p_wake_full;
		$fell(powerdown_chan_a) && $past(powerdown_chan_b) |-> s_full_wake;
	endproperty
	a_wake_full: assert property (p_wake_full) else $error("full wake");
	property p_code_cause;
		$changed(code_a) || $changed(code_b) |-> $past(frame_n, 2) && frame_n;
	endproperty
	a_code_cause: assert property (p_code_cause) else $error("code moved");
	property p_ctrl_cause;
		$changed({reference_select, powerdown_chan_a, powerdown_chan_b}) |-> $past(frame_n, 2);
	endproperty
	a_ctrl_cause: assert property (p_ctrl_cause) else $error("control moved");
	property p_busy_hold;
		!frame_n[*6] |-> $stable(code_a) && $stable(code_b) && $stable(reference_select);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("change in frame");
	property p_idle_hold;
		frame_n[*8] |-> $stable(code_b) && $stable(powerdown_chan_a) && $stable(powerdown_chan_b);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("change when idle");
endmodule

bind dac_word_decoder dac_word_decoder_assertions #(
	.WAKE_FULL_CYC(WAKE_FULL_CYC),
	.WAKE_PART_CYC(WAKE_PART_CYC)
) u_chk (
	.clk(clk), .reset(reset), .frame_n(frame_n), .code_a(code_a), .code_b(code_b),
	.reference_select(reference_select), .powerdown_chan_a(powerdown_chan_a),
	.powerdown_chan_b(powerdown_chan_b), .bias_powerdown(bias_powerdown),
	.valid_a(valid_a), .valid_b(valid_b)
);

// ---- testbench.sv ----
// self-checking bench of the serial word decoder
// assumes host model and checker compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk;
	logic       reset;
	logic       clk_en;
	wire        serial_clk;
	wire        serial_data;
	wire        frame_n;
	wire  [7:0] code_a;
	wire  [7:0] code_b;
	wire        reference_select;
	wire        powerdown_chan_a;
	wire        powerdown_chan_b;
	wire        bias_powerdown;
	wire        valid_a;
	wire        valid_b;
	int         bad_count;
	int         cmp_count;
	int         seed;
	int         ina, inb, outa, outb, ref_m, pda_m, pdb_m;
	logic [15:0] w;
	dac_word_decoder #(.WAKE_FULL_CYC(20), .WAKE_PART_CYC(5)) dut (
		.clk(clk), .reset(reset), .clk_en(clk_en), .serial_clk(serial_clk),
		.serial_data(serial_data), .frame_n(frame_n), .code_a(code_a), .code_b(code_b),
		.reference_select(reference_select), .powerdown_chan_a(powerdown_chan_a),
		.powerdown_chan_b(powerdown_chan_b), .bias_powerdown(bias_powerdown),
		.valid_a(valid_a), .valid_b(valid_b));
	dac_word_host host (.serial_clk(serial_clk), .serial_data(serial_data), .frame_n(frame_n));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic check_all();
		repeat (30) @(negedge clk);
		chk("code_a", 8'(outa), code_a); // code a
		chk("code_b", 8'(outb), code_b); // code b
		chk("reference_select", 8'(ref_m), {7'h00, reference_select}); // reference
		chk("powerdown_chan_a", 8'(pda_m), {7'h00, powerdown_chan_a}); // down a
		chk("powerdown_chan_b", 8'(pdb_m), {7'h00, powerdown_chan_b}); // down b
		chk("bias_powerdown", 8'(pda_m & pdb_m), {7'h00, bias_powerdown}); // bias
		chk("valid_a", 8'(!pda_m), {7'h00, valid_a}); // settled a
		chk("valid_b", 8'(!pdb_m), {7'h00, valid_b}); // settled b
	endtask
	task automatic send(input logic [15:0] cw);
		int d;
		int fn;
		host.send(cw, 16);
		d = cw[7:0];
		fn = cw[13] ? 4 : int'(cw[9:8]);
		ref_m = cw[15];
		pdb_m = cw[12];
		pda_m = cw[11];
		if (fn == 1 || fn == 4) begin
			if (cw[10]) inb = d;
			else ina = d;
		end
		if (fn == 0 || (fn == 3 && !cw[10])) outa = d;
		if (fn == 0 || (fn == 3 && cw[10])) outb = d;
		if (fn == 4 || (fn == 2 && !cw[10])) outa = ina;
		if (fn == 4 || (fn == 2 && cw[10])) outb = inb;
		check_all();
	endtask
	task automatic do_reset();
		@(negedge clk);
		reset = 1'b1;
		{ina, inb, outa, outb, ref_m, pda_m, pdb_m} = '0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		seed = 32'hBF8E;
		bad_count = 0;
		cmp_count = 0;
		w = 16'h0000;
		do_reset();
		check_all(); // cleared at power-on
		send(16'h0155); // input load keeps outputs at zero
		send(16'h1955); // both down, registers kept
		send(16'h0200); // full wake after both down
		for (int i = 0; i < 48; i++) begin
			w = 16'($random(seed));
			w[13] = i[3];
			w[10:8] = i[2:0];
			send(w); // every control code
		end
		// frozen enable hides a whole word
		@(negedge clk);
		clk_en = 1'b0;
		host.send(16'h0BFF, 16);
		@(negedge clk);
		clk_en = 1'b1;
		check_all(); // word unseen while frozen
		host.send(16'hFFFF, 12);
		check_all(); // short frame dropped
		host.send(16'h0BAA, 17);
		check_all(); // long frame dropped
		do_reset();
		check_all(); // second reset clears
		print_verdict();
	end
	// bounded run: about 80000 clock cycles
	initial begin
		#400000;
		bad_count++;
		print_verdict();
	end
endmodule
